// ### src/dps_defines.svh
// constants and summary for the drive protection supervisor
// Summary of operation
// - overload mode: off, low-speed compensated, uncompensated
// - overload coefficient scales drive rated current
// - stall protection enable and bus threshold
// - decelerating above stall threshold freezes frequency
// - stall hold over one minute raises fault
// - units digit picks pre-alarm monitoring window
// - tens digit: continue, or alarm and stop
// - hundreds digit picks motor or drive reference
// - pre-alarm only after full detection time
// - current dropping restarts detection timer
// - current limit threshold, percent of drive rating
// - limiting lowers frequency at programmed rate
// - limiting always in ramps, selectable at constant
// - auto reset retries count at interval
// - switch and external faults need manual reset
// - reset interval stops output, then catch spin
// - selector A: comm, contactor, memory fault action
// - selector B: undervoltage, retry interval, lock-up
// - keep three fault codes plus snapshot
// - snapshot holds voltage, current, frequency, reset zero
// - clear-memory command erases history and snapshot unless a fault is recorded in the same cycle
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_CLK_PERIOD_NS   100
`define DPS_FINE_TICK_NS    100000
`define DPS_FINE_CYCLES     (`DPS_FINE_TICK_NS / `DPS_CLK_PERIOD_NS)
`define DPS_COARSE_TICK_MS  100
`define DPS_FINE_PER_COARSE (`DPS_COARSE_TICK_MS * 1000000 / `DPS_FINE_TICK_NS)
`define DPS_STALL_TIMEOUT_S 60
`define DPS_STALL_TICKS     10'(`DPS_STALL_TIMEOUT_S * 1000 / `DPS_COARSE_TICK_MS)
`define DPS_MOL_TIMEOUT_S   60
`define DPS_MOL_TICKS       10'(`DPS_MOL_TIMEOUT_S * 1000 / `DPS_COARSE_TICK_MS)
`define DPS_LOWSPEED_FREQ   17'h00BB8
`define DPS_PCT_SCALE       32'h0000_03E8
`define DPS_RATE_STEP       14'h2710
`define DPS_RETRY_MAX       4'hA
`define DPS_INTERVAL_MIN    8'h14
`define DPS_CODE_NONE       5'h00
`define DPS_CODE_IGBT       5'h0A
`define DPS_CODE_DRV_OL     5'h0D
`define DPS_CODE_MOT_OL     5'h0E
`define DPS_CODE_EXT        5'h0F
`define DPS_CODE_COMM       5'h12
`define DPS_CODE_CONTACTOR  5'h13
`define DPS_CODE_NVM        5'h14
`define DPS_CODE_UNDERVOLT  5'h16
`define DPS_INIT_CLEAR      2'h1
`define DPS_LUTA_DEFAULT    6'h2A
`define DPS_LUTB_DEFAULT    11'h554
`define DPS_LUTB_UNITS      4'h0
`define DPS_LUTB_TENS       4'h2
`define DPS_LUTB_HUNDREDS   4'h4
`define DPS_LUTB_THOUSANDS  4'h7
`define DPS_SYNC_COMM       0
`define DPS_SYNC_CONTACTOR  1
`define DPS_SYNC_NVM        2
`define DPS_SYNC_UNDERVOLT  3
`define DPS_SYNC_MANRESET   4
`define DPS_T_STALL         0
`define DPS_T_PREALARM      1
`define DPS_T_MOTOR_OL      2
`define DPS_T_RETRY         3
`endif

// ### src/dps_pkg.sv
// types shared by the protection supervisor modules
package dps_pkg;
	// operating phase reported by the ramp generator
	typedef enum logic [1:0] {
		DPS_PH_STOP,
		DPS_PH_ACCEL,
		DPS_PH_DECEL,
		DPS_PH_CONST
	} dps_phase_t;

	// supervisor mode
	typedef enum logic [1:0] {
		DPS_RUN,
		DPS_RETRY_WAIT,
		DPS_LOCKED
	} dps_mode_t;

	// whole register state of the top module
	typedef struct packed {
		dps_mode_t   mode;      // supervisor mode
		logic [4:0]  sync1;     // first synchroniser stage
		logic [4:0]  sync2;     // second synchroniser stage
		logic [4:0]  sync3;     // edge history of stage two
		logic [9:0]  fine_cnt;  // fine divider
		logic [9:0]  coarse_cnt;// coarse divider
		logic        fine_tick; // fine enable pulse
		logic        coarse_tick;// coarse enable pulse
		logic [16:0] freq_cmd;  // commanded frequency
		logic [13:0] acc;       // ramp-down accumulator
		logic [3:0]  retries;   // auto resets used
		logic [4:0]  code;      // active fault code
		logic        catch_spin;// restart pulse
		logic        stall;     // stall hold flag
		logic        climit;    // current limit flag
		logic        relay;     // fault relay level
		logic [4:0]  hist0;     // latest fault type
		logic [4:0]  hist1;     // second latest
		logic [4:0]  hist2;     // third latest
		logic [9:0]  snap_v;    // bus voltage at fault
		logic [13:0] snap_i;    // current at fault
		logic [16:0] snap_f;    // frequency at fault
	} dps_state_t;
endpackage

// ### src/dps_tmr_if.sv
// link between the supervisor and one of its timers
`timescale 1ns/10ps
interface dps_tmr_if;
	logic       run;     // timer counts while high
	logic       tick;    // coarse enable pulse
	logic [9:0] limit;   // expiry in ticks
	logic       expired; // run lasted the whole limit
	modport ctl (output run, output tick, output limit, input expired);
	modport tmr (input run, input tick, input limit, output expired);
endinterface

// ### src/dps_timer.sv
// qualifying timer: expires after run holds for limit ticks
`timescale 1ns/10ps
module dps_timer (
	input  wire logic clk_in, // system clock
	input  wire logic rst_in, // synchronous reset
	dps_tmr_if.tmr    bus     // run, tick, limit, expired
);
	import dps_pkg::*;

	// counter and registered expiry
	typedef struct packed {
		logic [9:0] cnt;     // elapsed ticks
		logic       expired; // registered expiry
	} dps_tmr_state_t;

	dps_tmr_state_t s;      // present state
	dps_tmr_state_t next_s; // next state

	assign bus.expired = s.expired;

	// count while run holds, drop to zero otherwise
	always_comb begin
		next_s = s;
		if (!bus.run) begin
			next_s.cnt = 10'h000;
		end else if (bus.tick && s.cnt < bus.limit) begin
			next_s.cnt = s.cnt + 10'h001;
		end
		next_s.expired = bus.run && (next_s.cnt >= bus.limit);
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ### src/dps_top.sv
// drive protection supervisor top module
`timescale 1ns/10ps
`include "dps_defines.svh"
module dps_top #(
	parameter int         FINE_CYCLES  = `DPS_FINE_CYCLES,     // 100 us
	parameter int         FINE_PER_CRS = `DPS_FINE_PER_COARSE, // 100 ms
	parameter logic [5:0] LUT_A = `DPS_LUTA_DEFAULT,  // selector A table
	parameter logic [10:0] LUT_B = `DPS_LUTB_DEFAULT  // selector B table
) (
	input  wire logic              clk_in,      // 10 MHz clock
	input  wire logic              rst_in,      // sync reset, high
	input  wire dps_pkg::dps_phase_t phase_in,  // ramp phase
	input  wire logic [9:0]  bus_voltage_in,    // bus volts
	input  wire logic [9:0]  bus_nominal_in,    // bus 100 % volts
	input  wire logic [13:0] output_current_in, // current, 0.1 A
	input  wire logic [13:0] motor_rated_current_in, // 0.1 A
	input  wire logic [13:0] drive_rated_current_in, // 0.1 A
	input  wire logic [16:0] freq_ref_in,       // ramp freq, 0.01 Hz
	input  wire logic [1:0]  motor_overload_mode_in,        // 0..2
	input  wire logic [10:0] motor_overload_coefficient_in, // 0.1 %
	input  wire logic        stall_overvoltage_enable_in,   // enable
	input  wire logic [10:0] stall_overvoltage_threshold_in,// 0.1 %
	input  wire logic [2:0]  overload_detect_selector_in,   // digits
	input  wire logic [10:0] overload_prealarm_threshold_in,// 0.1 %
	input  wire logic [9:0]  overload_detect_time_in,       // 0.1 s
	input  wire logic [10:0] current_limit_threshold_in,    // 0.1 %
	input  wire logic [13:0] current_limit_ramp_rate_in,    // .01Hz/s
	input  wire logic current_limit_const_speed_enable_in,  // enable
	input  wire logic [3:0]  auto_reset_count_in,    // retries
	input  wire logic [7:0]  auto_reset_interval_in, // 0.1 s
	input  wire logic [2:0]  protective_action_sel_a_in, // digits
	input  wire logic [5:0]  protective_action_sel_b_in, // digits
	input  wire logic [1:0]  parameter_init_command_in,  // command
	input  wire logic        parameter_init_strobe_in,   // apply
	input  wire logic        fault_event_in,     // other fault pulse
	input  wire logic [4:0]  fault_code_in,      // its code
	input  wire logic        comm_fault_in,      // pin
	input  wire logic        contactor_fault_in, // pin
	input  wire logic        nvm_fault_in,       // pin
	input  wire logic        undervoltage_in,    // pin
	input  wire logic        manual_reset_in,    // pin
	output logic [16:0] freq_cmd_out,           // commanded freq
	output logic        run_enable_out,         // output enabled
	output logic        stall_hold_out,         // stall holding
	output logic        current_limit_out,      // limiting
	output logic        overload_prealarm_out,  // pre-alarm
	output logic        motor_overload_out,     // motor overload
	output logic        catch_spin_out,         // restart pulse
	output logic        fault_active_out,       // fault present
	output logic        fault_relay_out,        // fault relay
	output logic [4:0]  fault_code_out,         // active code
	output logic [4:0]  fault_type_latest_out,        // history
	output logic [4:0]  fault_type_second_latest_out, // history
	output logic [4:0]  fault_type_third_latest_out,  // history
	output logic [9:0]  fault_bus_voltage_out,        // snapshot
	output logic [13:0] fault_output_current_out,     // snapshot
	output logic [16:0] fault_output_frequency_out    // snapshot
);
	import dps_pkg::*;

	// measured value above pct (0.1 %) of reference
	function automatic logic above(input logic [13:0] meas,
		input logic [13:0] ref_val, input logic [10:0] pct);
		logic [31:0] lhs;
		logic [31:0] rhs;
		lhs = 32'(meas) * `DPS_PCT_SCALE;
		rhs = 32'(pct) * 32'(ref_val);
		return lhs > rhs;
	endfunction

	// one entry of a selector lookup table
	function automatic logic lut_b(input logic [3:0] base,
		input logic [1:0] val);
		logic [3:0] idx;
		idx = base + 4'(val);
		return LUT_B[idx];
	endfunction

	dps_state_t s;        // present state
	dps_state_t next_s;   // next state
	dps_tmr_if  tif[4](); // stall, pre-alarm, overload, retry

	logic       running;   // drive running, no fault
	logic       stall_now; // stall condition
	logic       cl_now;    // current limit condition
	logic       pa_over;   // pre-alarm current condition
	logic       mol_over;  // motor overload condition
	logic [10:0] mol_pct;  // effective overload coefficient
	logic [13:0] pa_ref;   // pre-alarm reference current
	logic [7:0] interval;  // clamped retry interval
	logic [3:0] max_retry; // clamped retry count
	logic       new_fault; // fault raised this cycle
	logic [4:0] new_code;  // its code
	logic       man_edge;  // manual reset rising edge
	logic [14:0] acc_sum;  // ramp accumulator plus rate, no wrap

	// timers share the coarse enable
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tmr
			assign tif[gi].tick = s.coarse_tick;
			dps_timer u_tmr (
				.clk_in (clk_in),
				.rst_in (rst_in),
				.bus    (tif[gi])
			);
		end
	endgenerate

	assign tif[`DPS_T_STALL].run     = stall_now;
	assign tif[`DPS_T_STALL].limit   = `DPS_STALL_TICKS;
	assign tif[`DPS_T_PREALARM].run   = pa_over;
	assign tif[`DPS_T_PREALARM].limit = overload_detect_time_in;
	assign tif[`DPS_T_MOTOR_OL].run   = mol_over;
	assign tif[`DPS_T_MOTOR_OL].limit = `DPS_MOL_TICKS;
	assign tif[`DPS_T_RETRY].run   = (s.mode == DPS_RETRY_WAIT);
	assign tif[`DPS_T_RETRY].limit = {2'h0, interval};

	// protection conditions from live measurements
	always_comb begin
		running = (s.mode == DPS_RUN) && (phase_in != DPS_PH_STOP);
		stall_now = running && stall_overvoltage_enable_in &&
			(phase_in == DPS_PH_DECEL) &&
			above({4'h0, bus_voltage_in}, {4'h0, bus_nominal_in},
				stall_overvoltage_threshold_in);
		cl_now = running && ((phase_in != DPS_PH_CONST) ||
			current_limit_const_speed_enable_in) &&
			above(output_current_in, drive_rated_current_in,
				current_limit_threshold_in);
		pa_ref = overload_detect_selector_in[2] ?
			drive_rated_current_in : motor_rated_current_in;
		pa_over = running && (!overload_detect_selector_in[0] ||
			(phase_in == DPS_PH_CONST)) &&
			above(output_current_in, pa_ref,
				overload_prealarm_threshold_in);
		// low-speed compensation lowers threshold by a quarter
		mol_pct = motor_overload_coefficient_in;
		if (motor_overload_mode_in == 2'h1 &&
			freq_ref_in < `DPS_LOWSPEED_FREQ) begin
			mol_pct = mol_pct - (mol_pct >> 2);
		end
		mol_over = running && (motor_overload_mode_in != 2'h0) &&
			(motor_overload_mode_in != 2'h3) &&
			above(output_current_in, drive_rated_current_in, mol_pct);
		interval = (auto_reset_interval_in < `DPS_INTERVAL_MIN) ?
			`DPS_INTERVAL_MIN : auto_reset_interval_in;
		max_retry = (auto_reset_count_in > `DPS_RETRY_MAX) ?
			`DPS_RETRY_MAX : auto_reset_count_in;
		man_edge = s.sync2[`DPS_SYNC_MANRESET] &&
			!s.sync3[`DPS_SYNC_MANRESET];
		acc_sum = {1'b0, s.acc} + {1'b0, current_limit_ramp_rate_in};
	end

	// fault source arbitration, first listed wins
	always_comb begin
		new_fault = 1'b0;
		new_code  = `DPS_CODE_NONE;
		if (s.mode == DPS_RUN) begin
			new_fault = 1'b1;
			if (fault_event_in) begin
				new_code = fault_code_in;
			end else if (tif[`DPS_T_STALL].expired) begin
				new_code = `DPS_CODE_EXT;
			end else if (tif[`DPS_T_PREALARM].expired &&
				overload_detect_selector_in[1]) begin
				new_code = overload_detect_selector_in[2] ?
					`DPS_CODE_DRV_OL : `DPS_CODE_MOT_OL;
			end else if (tif[`DPS_T_MOTOR_OL].expired) begin
				new_code = `DPS_CODE_MOT_OL;
			end else if (s.sync2[`DPS_SYNC_COMM] &&
				!LUT_A[{2'h0, protective_action_sel_a_in[0]}]) begin
				new_code = `DPS_CODE_COMM;
			end else if (s.sync2[`DPS_SYNC_CONTACTOR] &&
				!LUT_A[3'h2 + {2'h0, protective_action_sel_a_in[1]}]) begin
				new_code = `DPS_CODE_CONTACTOR;
			end else if (s.sync2[`DPS_SYNC_NVM] &&
				!LUT_A[3'h4 + {2'h0, protective_action_sel_a_in[2]}]) begin
				new_code = `DPS_CODE_NVM;
			end else if (s.sync2[`DPS_SYNC_UNDERVOLT] &&
				lut_b(`DPS_LUTB_THOUSANDS,
					protective_action_sel_b_in[5:4])) begin
				new_code = `DPS_CODE_UNDERVOLT;
			end else begin
				new_fault = 1'b0;
			end
		end
	end

	// next state of the whole supervisor
	always_comb begin
		next_s = s;
		next_s.catch_spin  = 1'b0;
		next_s.fine_tick   = 1'b0;
		next_s.coarse_tick = 1'b0;
		// two-stage synchronisers for pin inputs
		next_s.sync1 = {manual_reset_in, undervoltage_in, nvm_fault_in,
			contactor_fault_in, comm_fault_in};
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		// fine and coarse enable dividers
		if (s.fine_cnt == 10'(FINE_CYCLES - 1)) begin
			next_s.fine_cnt  = 10'h000;
			next_s.fine_tick = 1'b1;
			if (s.coarse_cnt == 10'(FINE_PER_CRS - 1)) begin
				next_s.coarse_cnt  = 10'h000;
				next_s.coarse_tick = 1'b1;
			end else begin
				next_s.coarse_cnt = s.coarse_cnt + 10'h001;
			end
		end else begin
			next_s.fine_cnt = s.fine_cnt + 10'h001;
		end
		next_s.stall  = stall_now;
		next_s.climit = cl_now;
		// output frequency shaping
		if (!running || new_fault) begin
			// zero frequency while stopped or faulted
			next_s.freq_cmd = 17'h00000;
			next_s.acc      = 14'h0000;
		end else if (stall_now) begin
			next_s.freq_cmd = s.freq_cmd;
		end else if (cl_now) begin
			if (s.fine_tick) begin
				if (acc_sum >= {1'b0, `DPS_RATE_STEP}) begin
					next_s.acc = 14'(acc_sum - {1'b0, `DPS_RATE_STEP});
					if (s.freq_cmd != 17'h00000) begin
						next_s.freq_cmd = s.freq_cmd - 17'h00001;
					end
				end else begin
					next_s.acc = acc_sum[13:0];
				end
			end
			if (freq_ref_in < next_s.freq_cmd) begin
				next_s.freq_cmd = freq_ref_in;
			end
		end else begin
			next_s.freq_cmd = freq_ref_in;
			next_s.acc      = 14'h0000;
		end
		if (parameter_init_strobe_in &&
			parameter_init_command_in == `DPS_INIT_CLEAR) begin
			next_s.hist0  = 5'h00;
			next_s.hist1  = 5'h00;
			next_s.hist2  = 5'h00;
			next_s.snap_v = 10'h000;
			next_s.snap_i = 14'h0000;
			next_s.snap_f = 17'h00000;
		end
		// supervisor sequence
		unique case (s.mode)
			DPS_RUN: begin
				if (new_fault) begin
					next_s.hist2  = s.hist1;
					next_s.hist1  = s.hist0;
					next_s.hist0  = new_code;
					next_s.snap_v = bus_voltage_in;
					next_s.snap_i = output_current_in;
					next_s.snap_f = freq_ref_in;
					next_s.code   = new_code;
					if (s.retries < max_retry &&
						new_code != `DPS_CODE_IGBT &&
						new_code != `DPS_CODE_EXT) begin
						next_s.mode = DPS_RETRY_WAIT;
					end else begin
						next_s.mode = DPS_LOCKED;
					end
				end
			end
			DPS_RETRY_WAIT: begin
				// restart on the fly after interval
				if (tif[`DPS_T_RETRY].expired) begin
					next_s.mode       = DPS_RUN;
					next_s.retries    = s.retries + 4'h1;
					next_s.code       = `DPS_CODE_NONE;
					next_s.catch_spin = 1'b1;
				end
			end
			DPS_LOCKED: begin
				// manual reset only
				if (man_edge) begin
					next_s.mode = DPS_RUN;
					next_s.code = `DPS_CODE_NONE;
				end
			end
			default: begin
				next_s.mode = DPS_LOCKED;
			end
		endcase
		if (man_edge) begin
			next_s.retries = 4'h0;
		end
		// relay level per state from table
		if (next_s.mode == DPS_LOCKED) begin
			next_s.relay = lut_b(`DPS_LUTB_HUNDREDS,
				protective_action_sel_b_in[3:2]);
		end else if (next_s.mode == DPS_RETRY_WAIT) begin
			next_s.relay = lut_b(`DPS_LUTB_TENS,
				{1'b0, protective_action_sel_b_in[1]});
		end else if (s.sync2[`DPS_SYNC_UNDERVOLT]) begin
			next_s.relay = lut_b(`DPS_LUTB_UNITS,
				{1'b0, protective_action_sel_b_in[0]});
		end else begin
			next_s.relay = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state
	assign freq_cmd_out          = s.freq_cmd;
	assign run_enable_out        = (s.mode == DPS_RUN);
	assign stall_hold_out        = s.stall;
	assign current_limit_out     = s.climit;
	assign overload_prealarm_out = tif[`DPS_T_PREALARM].expired;
	assign motor_overload_out    = tif[`DPS_T_MOTOR_OL].expired;
	assign catch_spin_out        = s.catch_spin;
	assign fault_active_out      = (s.mode != DPS_RUN);
	assign fault_relay_out       = s.relay;
	assign fault_code_out        = s.code;
	assign fault_type_latest_out        = s.hist0;
	assign fault_type_second_latest_out = s.hist1;
	assign fault_type_third_latest_out  = s.hist2;
	assign fault_bus_voltage_out        = s.snap_v;
	assign fault_output_current_out     = s.snap_i;
	assign fault_output_frequency_out   = s.snap_f;
endmodule

// ### verification/dps_asserts.sv
// assertion checker bound to the protection supervisor top
`timescale 1ns/10ps
module dps_asserts (
	input wire logic                clk_in,   // clock
	input wire logic                rst_in,   // reset
	input wire dps_pkg::dps_phase_t phase_in, // phase
	input wire logic [9:0]  bus_voltage_in,   // bus
	input wire logic [9:0]  bus_nominal_in,   // nominal
	input wire logic        stall_overvoltage_enable_in,    // on
	input wire logic [10:0] stall_overvoltage_threshold_in, // thr
	input wire logic        current_limit_const_speed_enable_in, // on
	input wire logic        parameter_init_strobe_in,  // strobe
	input wire logic [1:0]  parameter_init_command_in, // command
	input wire logic        fault_event_in,   // fault
	input wire logic [4:0]  fault_code_in,    // code
	input wire logic [16:0] freq_cmd_out,     // freq
	input wire logic        run_enable_out,   // run
	input wire logic        stall_hold_out,   // stall
	input wire logic        current_limit_out,// limit
	input wire logic        catch_spin_out,   // restart
	input wire logic        fault_active_out, // fault
	input wire logic [4:0]  fault_code_out,   // code
	input wire logic [4:0]  fault_type_latest_out,        // hist
	input wire logic [4:0]  fault_type_second_latest_out, // hist
	input wire logic [9:0]  fault_bus_voltage_out         // snap
);
	import dps_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic over_v; // bus above the stall point
	assign over_v = 32'(bus_voltage_in) * 1000 >
		32'(stall_overvoltage_threshold_in) * 32'(bus_nominal_in);
	AST_STALL_HOLD: assert property (
		run_enable_out && !fault_event_in && phase_in == DPS_PH_DECEL &&
		stall_overvoltage_enable_in && over_v |=> stall_hold_out)
		else $error("stall hold missing");
	AST_STALL_RELEASE: assert property (
		!over_v |=> !stall_hold_out) else $error("stall hold stuck");
	AST_FREEZE: assert property (
		(stall_hold_out && run_enable_out) ##1
		(stall_hold_out && run_enable_out) |-> $stable(freq_cmd_out))
		else $error("frequency moved in stall");
	AST_CAPTURE: assert property (
		run_enable_out && fault_event_in |=> fault_active_out &&
		freq_cmd_out == 17'h00000 &&
		fault_code_out == $past(fault_code_in) &&
		fault_type_latest_out == $past(fault_code_in))
		else $error("fault not captured");
	AST_HIST_SHIFT: assert property (
		run_enable_out && fault_event_in |=>
		fault_type_second_latest_out == $past(fault_type_latest_out))
		else $error("history not shifted");
	AST_CATCH: assert property (
		catch_spin_out |-> (run_enable_out && fault_code_out == 5'h00)
		##1 !catch_spin_out) else $error("bad restart pulse");
	AST_ZERO_FREQ: assert property (
		fault_active_out |-> freq_cmd_out == 17'h00000)
		else $error("output not stopped in fault");
	AST_CLEAR: assert property (
		parameter_init_strobe_in && parameter_init_command_in == 2'h1 &&
		fault_active_out |=> fault_type_latest_out == 5'h00 &&
		fault_bus_voltage_out == 10'h000) else $error("history kept");
	AST_CL_CONST: assert property (
		(phase_in == DPS_PH_CONST && !current_limit_const_speed_enable_in)
		|| phase_in == DPS_PH_STOP |=> !current_limit_out)
		else $error("limiting while disabled");
endmodule
bind dps_top dps_asserts u_chk (.*);

// ### verification/dps_power_stage.sv
// behavioural power stage with bus and current sensing
`timescale 1ns/10ps
module dps_power_stage (
	input  wire logic        run_in,     // stage switching
	input  wire logic [9:0]  regen_v_in, // bus volts to show
	input  wire logic [13:0] load_i_in,  // load when running
	output logic      [9:0]  bus_v_out,  // sensed bus
	output logic      [13:0] current_out // sensed current
);
	// no current flows while the stage is stopped
	assign bus_v_out   = regen_v_in;
	assign current_out = run_in ? load_i_in : 14'h0000;
endmodule

// ### verification/dps_top_tb.sv
// self-checking bench for the protection supervisor
`timescale 1ns/10ps
module dps_top_tb;
	import dps_pkg::*;
	logic clk_in = 1'b0, rst_in = 1'b1; // clock, reset
	dps_phase_t phase_in = DPS_PH_STOP; // ramp phase
	logic [9:0]  bus_voltage_in, regen_v = 10'h000, bus_nominal_in = 10'h1F4;
	logic [13:0] output_current_in, load_i = 14'h0000;
	logic [13:0] motor_rated_current_in = 14'h0064;
	logic [13:0] drive_rated_current_in = 14'h00C8;
	logic [13:0] current_limit_ramp_rate_in = 14'h1388;
	logic [16:0] freq_ref_in = 17'h003E8, f0;
	logic [1:0]  motor_overload_mode_in = 2'h0;
	logic [1:0]  parameter_init_command_in = 2'h0;
	logic [10:0] motor_overload_coefficient_in = 11'h3E8;
	logic [10:0] stall_overvoltage_threshold_in = 11'h578;
	logic [10:0] overload_prealarm_threshold_in = 11'h514;
	logic [10:0] current_limit_threshold_in = 11'h7D0;
	logic stall_overvoltage_enable_in = 1'b1;
	logic current_limit_const_speed_enable_in = 1'b1;
	logic [2:0]  overload_detect_selector_in = 3'h0;
	logic [2:0]  protective_action_sel_a_in = 3'h7;
	logic [5:0]  protective_action_sel_b_in = 6'h00;
	logic [9:0]  overload_detect_time_in = 10'h003;
	logic [3:0]  auto_reset_count_in = 4'h0;
	logic [7:0]  auto_reset_interval_in = 8'h14;
	logic [4:0]  fault_code_in = 5'h00;
	logic parameter_init_strobe_in = 1'b0, fault_event_in = 1'b0;
	logic comm_fault_in = 1'b0, contactor_fault_in = 1'b0;
	logic nvm_fault_in = 1'b0, undervoltage_in = 1'b0, manual_reset_in = 1'b0;
	logic [16:0] freq_cmd_out, fault_output_frequency_out;
	logic run_enable_out, stall_hold_out, current_limit_out, catch_spin_out;
	logic overload_prealarm_out, motor_overload_out, fault_active_out;
	logic fault_relay_out;
	logic [4:0]  fault_code_out, fault_type_latest_out;
	logic [4:0]  fault_type_second_latest_out, fault_type_third_latest_out;
	logic [9:0]  fault_bus_voltage_out;
	logic [13:0] fault_output_current_out;
	logic [4:0]  pin_code [4] = '{5'h12, 5'h13, 5'h14, 5'h16};
	int err_total = 0, comparisons = 0, cycles = 0, i;
	dps_top #(.FINE_CYCLES(4), .FINE_PER_CRS(4)) u_dut (.*);
	dps_power_stage u_stage (.run_in(run_enable_out), .regen_v_in(regen_v),
		.load_i_in(load_i), .bus_v_out(bus_voltage_in),
		.current_out(output_current_in));
	initial forever #50 clk_in = ~clk_in;
	// cut a hang short
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			give_verdict();
		end
	end
	task check(input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task wait_fault(input int lim);
		for (int k = 0; k < lim && fault_active_out !== 1'b1; k++)
			tick(1);
	endtask
	task man_reset;
		manual_reset_in = 1'b1;
		tick(6);
		manual_reset_in = 1'b0;
		tick(6);
	endtask
	task pulse_fault(input logic [4:0] code);
		fault_code_in = code;
		fault_event_in = 1'b1;
		tick(1);
		fault_event_in = 1'b0;
	endtask
	task give_verdict;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		tick(10);
		rst_in = 1'b0;
		phase_in = DPS_PH_DECEL;
		tick(2);
		check(fault_bus_voltage_out, 10'h000);
		// stall hold, freeze, release, then timeout
		regen_v = 10'h2C0;
		tick(2);
		check(stall_hold_out, 1'b1);
		freq_ref_in = 17'h00384;
		tick(2);
		check(freq_cmd_out, 17'h003E8);
		regen_v = 10'h2B0;
		tick(2);
		check(freq_cmd_out, 17'h00384);
		auto_reset_count_in = 4'h5;
		regen_v = 10'h2C0;
		tick(9000);
		check(fault_active_out, 1'b0);
		wait_fault(2000);
		check(fault_code_out, 5'h0F);
		check(fault_bus_voltage_out, 10'h2C0);
		check(fault_output_frequency_out, 17'h00384);
		tick(400);
		check(fault_active_out, 1'b1);
		regen_v = 10'h2B0;
		phase_in = DPS_PH_CONST;
		auto_reset_count_in = 4'h0;
		man_reset();
		// ignored pin, then each pin trips
		comm_fault_in = 1'b1;
		tick(10);
		check(fault_active_out, 1'b0);
		comm_fault_in = 1'b0;
		tick(5);
		protective_action_sel_a_in = 3'h0;
		protective_action_sel_b_in = 6'h10;
		for (i = 0; i < 4; i++) begin
			{undervoltage_in, nvm_fault_in, contactor_fault_in,
				comm_fault_in} = 4'(1 << i);
			wait_fault(20);
			check(fault_code_out, pin_code[i]);
			{undervoltage_in, nvm_fault_in, contactor_fault_in,
				comm_fault_in} = 4'h0;
			man_reset();
		end
		// pre-alarm qualification with a restart
		load_i = 14'h008C;
		tick(20);
		load_i = 14'h0000;
		tick(3);
		load_i = 14'h008C;
		tick(25);
		check(overload_prealarm_out, 1'b0);
		tick(40);
		check(overload_prealarm_out, 1'b1);
		for (i = 0; i < 2; i++) begin
			overload_detect_selector_in = i ? 3'h6 : 3'h2;
			load_i = 14'h012C;
			wait_fault(200);
			check(fault_code_out, i ? 5'h0D : 5'h0E);
			load_i = 14'h0000;
			man_reset();
		end
		check(fault_type_third_latest_out, 5'h16);
		// motor overload at half of drive rating
		overload_detect_selector_in = 3'h0;
		motor_overload_mode_in = 2'h2;
		motor_overload_coefficient_in = 11'h1F4;
		load_i = 14'h00C8;
		wait_fault(12000);
		check(fault_code_out, 5'h0E);
		check(motor_overload_out, 1'b1);
		check(fault_output_current_out, 14'h00C8);
		load_i = 14'h0000;
		motor_overload_mode_in = 2'h0;
		man_reset();
		// current limiting ramp and constant-speed selection
		phase_in = DPS_PH_ACCEL;
		load_i = 14'h01F4;
		tick(3);
		check(current_limit_out, 1'b1);
		f0 = freq_cmd_out;
		tick(80);
		check((f0 - freq_cmd_out) inside {17'h9, 17'hA, 17'hB}, 1'b1);
		phase_in = DPS_PH_CONST;
		current_limit_const_speed_enable_in = 1'b0;
		tick(3);
		check(freq_cmd_out, 17'h00384);
		load_i = 14'h0000;
		// one automatic retry, then lock-up
		auto_reset_count_in = 4'h1;
		pulse_fault(5'h03);
		check(fault_code_out, 5'h03);
		check(freq_cmd_out, 17'h00000);
		check(fault_relay_out, 1'b1);
		tick(250);
		check(fault_active_out, 1'b1);
		for (i = 0; i < 200 && catch_spin_out !== 1'b1; i++)
			tick(1);
		check(catch_spin_out, 1'b1);
		check(fault_code_out, 5'h00);
		check(fault_relay_out, 1'b0);
		tick(2);
		pulse_fault(5'h05);
		tick(400);
		check(fault_active_out, 1'b1);
		check(fault_type_second_latest_out, 5'h03);
		// clear-memory command
		parameter_init_command_in = 2'h1;
		parameter_init_strobe_in = 1'b1;
		tick(1);
		parameter_init_strobe_in = 1'b0;
		check(fault_type_latest_out, 5'h00);
		check(fault_type_third_latest_out, 5'h00);
		check(fault_output_frequency_out, 17'h00000);
		give_verdict();
	end
endmodule
